// >>> rtl/ext_irq_defs.svh
// register offsets, field positions and reset values of the external interrupt block
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH
`define OFF_PENDING 16'ha814
`define OFF_CFG_A 16'ha860
`define OFF_CFG_B 16'ha864
`define OFF_CFG_C 16'ha868
`define OFF_CFG_D 16'ha86c
`define OFF_DBG_CFG 16'hbc00
`define OFF_DBG_STAT 16'hbc04
`define OFF_IRQ_MASK 16'ha818
`define OFF_SEL_C 16'hbc14
`define OFF_SEL_D 16'hbc18
`define CFG_FILT_BIT 8
`define CFG_MODE_HI 7
`define CFG_MODE_LO 5
`define CFG_WIDTH 9
`define DBG_DIS_BIT 5
`define DBG_REGEN_BIT 4
`define DBG_RSVD_BIT 3
`define DBG_CFG_RESET 6'h10
`define STAT_BOOT_BIT 3
`define STAT_FORCE_BIT 1
`define STAT_SW_BIT 0
`define SEL_C_RESET 5'h0f
`define SEL_D_RESET 5'h10
`define SEL_MAX 5'h17
`define FILT_LEN 3'h3
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

// >>> rtl/ext_irq_pkg.sv
// types of the external interrupt block
package ext_irq_pkg;
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_RISE = 3'h1,
        MODE_FALL = 3'h2,
        MODE_BOTH = 3'h3,
        MODE_HIGH = 3'h4,
        MODE_LOW = 3'h5
    } trig_mode_t;

    typedef enum logic [0:0] {
        BOOT_WAIT = 1'b0,
        BOOT_DONE = 1'b1
    } boot_state_t;

    typedef struct packed {
        logic [3:0][8:0] cfg;
        logic [3:0] pending;
        logic [3:0] mask;
        logic [4:0] sel_c;
        logic [4:0] sel_d;
        logic [5:0] dbg_cfg;
        logic boot_pin_sampled;
        boot_state_t boot_state;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0][2:0] filt_cnt;
        logic [3:0] filt_level;
        logic [3:0] prev_level;
        logic [4:0] dbg_sync1;
        logic [4:0] dbg_sync2;
        logic debug_active;
        logic dph_valid;
        logic dph_write;
        logic [15:0] dph_addr;
        logic [31:0] rdata;
        logic irq;
        logic dbg_enable;
        logic regen_override;
    } state_t;
endpackage

// >>> rtl/ext_irq_ctrl.sv
// external interrupt channels with debug override and status registers
`include "ext_irq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ext_irq_ctrl (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [7:0] I_PORT_A,
    input wire logic [7:0] I_PORT_B,
    input wire logic [7:0] I_PORT_C,
    input wire logic I_BOOT_SELECT_PIN_N,
    input wire logic I_DEBUGGER_FORCED,
    input wire logic I_SERIAL_WIRE_ENABLED,
    input wire logic I_DEBUG_REQUEST,
    input wire logic I_RSVD_DBG_BIT,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic O_IRQ,
    output logic [3:0] O_EXT_IRQ_PENDING,
    output logic O_DEBUG_ENABLE,
    output logic O_REGULATOR_OVERRIDE
);
    ext_irq_pkg::state_t r;
    ext_irq_pkg::state_t next_r;

    logic [3:0] raw_pin;

    // pin lookup for a select code, reserved codes read as low
    function automatic logic pick_pin(input logic [4:0] code,
            input logic [23:0] pins);
        logic res;
        res = 1'b0;
        if (code <= `SEL_MAX) begin
            res = pins[code];
        end
        return res;
    endfunction

    always_comb begin
        raw_pin[0] = I_PORT_A[0];
        raw_pin[1] = I_PORT_A[1];
        raw_pin[2] = pick_pin(r.sel_c, {I_PORT_C, I_PORT_B, I_PORT_A});
        raw_pin[3] = pick_pin(r.sel_d, {I_PORT_C, I_PORT_B, I_PORT_A});
    end

    // trigger detection for one channel
    function automatic logic trig_hit(input logic [2:0] mode,
            input logic prev, input logic cur);
        logic hit;
        hit = 1'b0;
        case (ext_irq_pkg::trig_mode_t'(mode))
            ext_irq_pkg::MODE_OFF: hit = 1'b0;
            ext_irq_pkg::MODE_RISE: hit = cur & ~prev;
            ext_irq_pkg::MODE_FALL: hit = ~cur & prev;
            ext_irq_pkg::MODE_BOTH: hit = cur ^ prev;
            ext_irq_pkg::MODE_HIGH: hit = cur;
            ext_irq_pkg::MODE_LOW: hit = ~cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    logic [3:0] event_hit;
    logic [3:0] chan_level;
    logic wr_go;
    logic [15:0] a;
    logic [31:0] wd;

    always_comb begin
        next_r = r;
        a = r.dph_addr;
        wd = I_HWDATA;
        wr_go = r.dph_valid & r.dph_write;
        event_hit = 4'h0;
        chan_level = 4'h0;
        // two-stage pin synchroniser
        next_r.sync1 = raw_pin;
        next_r.sync2 = r.sync1;
        // boot and reserved pins ride a separate two-stage chain with the debug lines
        next_r.dbg_sync1 = {I_RSVD_DBG_BIT, I_BOOT_SELECT_PIN_N,
            I_DEBUG_REQUEST, I_DEBUGGER_FORCED, I_SERIAL_WIRE_ENABLED};
        next_r.dbg_sync2 = r.dbg_sync1;
        for (int i = 0; i < 4; i++) begin
            // filter: level must hold for a few cycles
            if (r.sync2[i] == r.filt_level[i]) begin
                next_r.filt_cnt[i] = 3'h0;
            end else if (r.filt_cnt[i] == `FILT_LEN) begin
                next_r.filt_level[i] = r.sync2[i];
                next_r.filt_cnt[i] = 3'h0;
            end else begin
                next_r.filt_cnt[i] = r.filt_cnt[i] + 3'h1;
            end
            chan_level[i] = r.cfg[i][`CFG_FILT_BIT] ?
                r.filt_level[i] : r.sync2[i];
            next_r.prev_level[i] = chan_level[i];
            event_hit[i] = trig_hit(r.cfg[i][`CFG_MODE_HI:`CFG_MODE_LO],
                r.prev_level[i], chan_level[i]);
        end
        // bus address phase capture
        if (I_HREADY) begin
            next_r.dph_valid = I_HSEL & (I_HTRANS == `HTRANS_NONSEQ);
            next_r.dph_write = I_HWRITE;
            next_r.dph_addr = I_HADDR[15:0];
        end
        next_r.rdata = 32'h0;
        if (I_HREADY & I_HSEL & (I_HTRANS == `HTRANS_NONSEQ) & ~I_HWRITE) begin
            case (I_HADDR[15:0])
                `OFF_PENDING: next_r.rdata = {28'h0, r.pending};
                `OFF_IRQ_MASK: next_r.rdata = {28'h0, r.mask};
                `OFF_CFG_A: next_r.rdata = {23'h0, r.cfg[0]};
                `OFF_CFG_B: next_r.rdata = {23'h0, r.cfg[1]};
                `OFF_CFG_C: next_r.rdata = {23'h0, r.cfg[2]};
                `OFF_CFG_D: next_r.rdata = {23'h0, r.cfg[3]};
                `OFF_SEL_C: next_r.rdata = {27'h0, r.sel_c};
                `OFF_SEL_D: next_r.rdata = {27'h0, r.sel_d};
                `OFF_DBG_CFG: next_r.rdata = {26'h0, r.dbg_cfg};
                `OFF_DBG_STAT: next_r.rdata = {28'h0, r.boot_pin_sampled,
                    1'b0, r.dbg_sync2[1], r.dbg_sync2[0]};
                default: next_r.rdata = 32'h0;
            endcase
        end
        if (wr_go) begin
            case (a)
                `OFF_IRQ_MASK: next_r.mask = wd[3:0];
                `OFF_CFG_A: next_r.cfg[0] = wd[`CFG_WIDTH-1:0];
                `OFF_CFG_B: next_r.cfg[1] = wd[`CFG_WIDTH-1:0];
                `OFF_CFG_C: next_r.cfg[2] = wd[`CFG_WIDTH-1:0];
                `OFF_CFG_D: next_r.cfg[3] = wd[`CFG_WIDTH-1:0];
                `OFF_SEL_C: next_r.sel_c = wd[4:0];
                `OFF_SEL_D: next_r.sel_d = wd[4:0];
                `OFF_DBG_CFG: next_r.dbg_cfg = {wd[5:4], r.dbg_cfg[3], 3'h0};
                default: next_r.mask = r.mask;
            endcase
        end
        // reserved bit follows hardware every cycle, the value software writes to it is ignored
        next_r.dbg_cfg[`DBG_RSVD_BIT] = r.dbg_sync2[4];
        // write one clears, new event wins
        if (wr_go && a == `OFF_PENDING) begin
            next_r.pending = r.pending & ~wd[3:0];
        end
        next_r.pending = next_r.pending | event_hit;
        if (r.boot_state == ext_irq_pkg::BOOT_WAIT) begin
            next_r.boot_pin_sampled = ~r.dbg_sync2[3];
            next_r.boot_state = ext_irq_pkg::BOOT_DONE;
        end
        // debug interface stays active, even when disabled, until the debug request drops
        if (r.dbg_sync2[2] & (~r.dbg_cfg[`DBG_DIS_BIT] | r.debug_active)) begin
            next_r.debug_active = 1'b1;
        end else if (~r.dbg_sync2[2]) begin
            next_r.debug_active = 1'b0;
        end
        next_r.dbg_enable = ~r.dbg_cfg[`DBG_DIS_BIT] | r.debug_active;
        next_r.regen_override = ~r.dbg_cfg[`DBG_REGEN_BIT];
        next_r.irq = |(next_r.pending & r.mask);
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            r <= '0;
            r.dbg_cfg <= `DBG_CFG_RESET;
            r.sel_c <= `SEL_C_RESET;
            r.sel_d <= `SEL_D_RESET;
            r.dbg_enable <= 1'b1;
            r.regen_override <= 1'b0;
            // chain runs in reset so the boot level is settled at release
            r.dbg_sync1 <= next_r.dbg_sync1;
            r.dbg_sync2 <= next_r.dbg_sync2;
        end else begin
            r <= next_r;
        end
    end

    assign O_HRDATA = r.rdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_IRQ = r.irq;
    assign O_EXT_IRQ_PENDING = r.pending;
    assign O_DEBUG_ENABLE = r.dbg_enable;
    assign O_REGULATOR_OVERRIDE = r.regen_override;
endmodule

`default_nettype wire

// >>> bench/ext_irq_monitor.sv
// assertions on the ports of the external interrupt block
`timescale 1ns/1ps
`default_nettype none
module ext_irq_monitor (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic I_HSEL,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic O_IRQ,
    input wire logic [3:0] O_EXT_IRQ_PENDING,
    input wire logic O_DEBUG_ENABLE,
    input wire logic O_REGULATOR_OVERRIDE
);
    logic wr;
    logic rd;
    assign wr = I_HSEL && I_HTRANS == 2'h2 && I_HREADY && I_HWRITE;
    assign rd = I_HSEL && I_HTRANS == 2'h2 && I_HREADY && !I_HWRITE;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    ready_high_a: assert property (O_HREADYOUT) else $error("ready low");
    resp_okay_a: assert property (!O_HRESP) else $error("resp not okay");
    reset_values_a: assert property ($rose(I_NRST) |->
        O_EXT_IRQ_PENDING == 4'h0 && !O_IRQ && !O_REGULATOR_OVERRIDE
        && O_DEBUG_ENABLE) else $error("bad value after reset");
    idle_rdata_a: assert property (!$past(rd) |-> O_HRDATA == 32'h0)
        else $error("read data outside data phase");
    pending_hold_a: assert property (
        |($past(O_EXT_IRQ_PENDING) & ~O_EXT_IRQ_PENDING) |->
        $past(wr, 2) || $past(wr, 3)) else $error("flag lost");
    irq_follow_a: assert property (O_EXT_IRQ_PENDING == 4'h0 &&
        $past(O_EXT_IRQ_PENDING) == 4'h0 |-> !O_IRQ)
        else $error("irq without flag");
    override_hold_a: assert property ($changed(O_REGULATOR_OVERRIDE)
        |-> $past(wr, 2) || $past(wr, 3)) else $error("override moved");
    debug_block_a: assert property ($fell(O_DEBUG_ENABLE) |->
        $past(wr, 2) || $past(wr, 3)) else $error("debug dropped");
endmodule
`default_nettype wire

// >>> bench/pin_model.sv
// far side model: port pins, boot pin and debugger cable
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    output logic [23:0] o_pins,
    output logic [4:0] o_ctl
);
    // ctl: boot pin low, cable forced, serial wire on, no request
    initial begin
        o_pins = 24'h0;
        o_ctl = 5'b01100;
    end
    // levels change at any edge of the caller, unsynchronised
    task automatic set_pin(input int i, input logic v);
        o_pins[i] <= v;
    endtask
    task automatic set_ctl(input logic [4:0] v);
        o_ctl <= v;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench of the external interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic hrdy, hresp, irq, dben, rego;
    logic [3:0] pend;
    logic [4:0] ctl;
    logic [23:0] pins;
    int mismatches = 0, compares = 0, cyc = 0;
    always #25 clk = ~clk;
    pin_model pin_model_i (.o_pins(pins), .o_ctl(ctl));
    ext_irq_ctrl ext_irq_ctrl_i (.I_CLK_SYS(clk), .I_NRST(nrst),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hrdy), .I_PORT_A(pins[7:0]), .I_PORT_B(pins[15:8]),
        .I_PORT_C(pins[23:16]), .I_BOOT_SELECT_PIN_N(ctl[4]),
        .I_DEBUGGER_FORCED(ctl[3]), .I_SERIAL_WIRE_ENABLED(ctl[2]),
        .I_DEBUG_REQUEST(ctl[1]), .I_RSVD_DBG_BIT(ctl[0]),
        .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
        .O_IRQ(irq), .O_EXT_IRQ_PENDING(pend), .O_DEBUG_ENABLE(dben),
        .O_REGULATOR_OVERRIDE(rego));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {16'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(d, e);
    endtask
    task automatic s_reset;
        pin_model_i.set_ctl(5'b11100);
        tick(4);
        rdchk(16'hbc04, 32'hb);
        rdchk(16'hbc00, 32'h10);
        rdchk(16'ha814, 32'h0);
        rdchk(16'ha860, 32'h0);
        bus(1'b1, 16'h0100, 32'hffff);
        rdchk(16'h0100, 32'h0);
    endtask
    task automatic s_modes;
        logic [5:0] er;
        logic [5:0] ef;
        er = 6'b111010;
        ef = 6'b111100;
        for (int m = 0; m < 6; m++) begin
            bus(1'b1, 16'ha860, {24'h0, m[2:0], 5'h0});
            tick(6);
            bus(1'b1, 16'ha814, 32'hf);
            pin_model_i.set_pin(0, 1'b1);
            tick(8);
            rdchk(16'ha814, {31'h0, er[m]});
            bus(1'b1, 16'ha814, 32'hf);
            pin_model_i.set_pin(0, 1'b0);
            tick(8);
            rdchk(16'ha814, {31'h0, ef[m]});
        end
    endtask
    task automatic s_filter;
        for (int f = 0; f < 3; f++) begin
            bus(1'b1, 16'ha860, f > 0 ? 32'h120 : 32'h20);
            bus(1'b1, 16'ha814, 32'hf);
            pin_model_i.set_pin(0, 1'b1);
            tick(f == 2 ? 8 : 2);
            pin_model_i.set_pin(0, 1'b0);
            tick(12);
            rdchk(16'ha814, f == 1 ? 32'h0 : 32'h1);
        end
    endtask
    task automatic s_chans;
        bus(1'b1, 16'ha860, 32'h0);
        bus(1'b1, 16'hbc14, 32'h17);
        bus(1'b1, 16'hbc18, 32'h08);
        for (int k = 1; k < 4; k++) begin
            bus(1'b1, 16'ha860 + 16'(4 * k), 32'h20);
            bus(1'b1, 16'ha814, 32'hf);
            pin_model_i.set_pin(k == 1 ? 1 : k == 2 ? 23 : 8, 1'b1);
            tick(8);
            rdchk(16'ha814, 32'h1 << k);
            chk({31'h0, irq}, 32'h0);
        end
        bus(1'b1, 16'ha818, 32'h8);
        rdchk(16'ha818, 32'h8);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 16'ha814, 32'h8);
        tick(2);
        chk({27'h0, pend, irq}, 32'h0);
    endtask
    task automatic s_debug;
        bus(1'b0, 16'hbc00, 32'h0);
        bus(1'b1, 16'hbc00, (d & 32'h8) | 32'h20);
        tick(4);
        chk({30'h0, dben, rego}, 32'h1);
        pin_model_i.set_ctl(5'b11110);
        tick(4);
        chk({30'h0, dben, rego}, 32'h1);
        bus(1'b1, 16'hbc00, 32'h0);
        tick(4);
        bus(1'b1, 16'hbc00, 32'h20);
        tick(4);
        chk({30'h0, dben, rego}, 32'h3);
        bus(1'b1, 16'hbc00, 32'h10);
        pin_model_i.set_ctl(5'b11101);
        tick(4);
        chk({30'h0, dben, rego}, 32'h2);
        rdchk(16'hbc00, 32'h18);
        pin_model_i.set_ctl(5'b10100);
        tick(4);
        rdchk(16'hbc04, 32'h9);
    endtask
    task automatic s_reboot;
        nrst <= 1'b0;
        tick(10);
        nrst <= 1'b1;
        tick(1);
        rdchk(16'hbc04, 32'h1);
        rdchk(16'hbc00, 32'h10);
        rdchk(16'ha814, 32'h0);
        chk({30'h0, dben, rego}, 32'h2);
    endtask
    initial begin
        tick(10);
        nrst <= 1'b1;
        tick(1);
        s_reset;
        s_modes;
        s_filter;
        s_chans;
        s_debug;
        s_reboot;
        report_and_stop;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
endmodule
bind ext_irq_ctrl ext_irq_monitor ext_irq_monitor_i (.I_CLK_SYS(I_CLK_SYS),
    .I_NRST(I_NRST), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ),
    .O_EXT_IRQ_PENDING(O_EXT_IRQ_PENDING), .O_DEBUG_ENABLE(O_DEBUG_ENABLE),
    .O_REGULATOR_OVERRIDE(O_REGULATOR_OVERRIDE));
`default_nettype wire
